// ---- rtl/qdu_regs.vh ----
// Constants for the quad DAC update control block: frame layout, command
// codes, reset values. Definitions only; included by the design files.
// Functional notes
// - Command 0101 loads the 4-bit strobe mask from DB3..DB0, address ignored.
// - All strobe mask bits are zero after power-up.
// - A masked channel ignores the strobe pin and sees it as high; code masks only strobe falls, 0001 writes use raw strobe level.
// - Command 0001 writes input register; DAC register too only when strobe low.
// - Command 0010 copies input register to DAC register, input unchanged.
// - Command 0011 writes input and DAC register regardless of strobe.
// - Strobe falling edge copies input to DAC on every unmasked channel.
// - With the strobe held low permanently the mask bits are disregarded.
// - While reset pin is low, outputs forced to clear code chosen by select.
// - After reset release, outputs hold cleared value until reprogrammed.
// - While reset pin is low, no command or strobe updates any output.
// - Command 0110 performs software reset to the power-on reset code.
// - During power-on reset, strobe and reset pin activity is ignored.
// - Power-up code is zero or midscale by select pin, held until written.
// - Reference on at power-up; command 0111 DB0 sets off (1) or on (0).
// - Command bits sit in DB23..DB20; reference command ignores DB19..DB1.
// - 24-bit frames are acted on at the rising edge of frame sync.
// - Strobe low during 0001: both registers update at frame sync rise.
// - Strobe high during writes: DAC update deferred to later strobe fall.
`ifndef QDU_REGS_VH
`define QDU_REGS_VH

`define QDU_FRAME_BITS   24
`define QDU_CMD_MSB      23
`define QDU_CMD_LSB      20
`define QDU_ADDR_MSB     19
`define QDU_ADDR_LSB     16
`define QDU_DATA_MSB     15
`define QDU_DATA_LSB     0
`define QDU_CMD_WR_IN    4'h1
`define QDU_CMD_UPD_DAC  4'h2
`define QDU_CMD_WR_UPD   4'h3
`define QDU_CMD_MASK     4'h5
`define QDU_CMD_SW_RST   4'h6
`define QDU_CMD_REF      4'h7
`define QDU_MASK_RESET   4'h0
`define QDU_REF_RESET    1'h0
`define QDU_CODE_ZERO    16'h0000
`define QDU_CODE_MID     16'h8000
`define QDU_POR_CYCLES   8

`endif

// ---- rtl/qdu_channel.v ----
// One DAC channel: input register and DAC register pair.
// Assumes load requests come from the control logic on the same clock.
`timescale 1ns/1ps
`include "qdu_regs.vh"
module qdu_channel (
    // Clock and reset
    input  wire        clock_i,
    input  wire        rst_n_i,
    // Controls
    input  wire        clear_i,
    input  wire [15:0] clear_code_i,
    input  wire        wr_input_i,
    input  wire        wr_dac_i,
    input  wire        copy_i,
    input  wire [15:0] data_i,
    // Outputs
    output reg  [15:0] dac_o
);
    reg [15:0] input_r;

    // Register pair; clear dominates, direct write beats copy
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            input_r <= `QDU_CODE_ZERO;
            dac_o   <= `QDU_CODE_ZERO;
        end else if (clear_i) begin
            input_r <= clear_code_i;
            dac_o   <= clear_code_i;
        end else begin
            if (wr_input_i)
                input_r <= data_i;
            if (wr_dac_i)
                dac_o <= data_i;
            else if (copy_i)
                dac_o <= input_r;
        end
    end
endmodule // qdu_channel

// ---- rtl/qdu_ctrl.v ----
// Command interpreter of a quad DAC: serial frames, strobe mask,
// hardware and software reset, reference setup.
// Assumes serial clock, frame sync, data and all pins are asynchronous
// to clock_i and much slower than it.
`timescale 1ns/1ps
`include "qdu_regs.vh"
module qdu_ctrl #(
    parameter POR_CYCLES = `QDU_POR_CYCLES
) (
    // Clock and reset
    input  wire        clock_i,
    input  wire        rst_n_i,
    // Serial link
    input  wire        sclk_i,
    input  wire        sync_n_i,
    input  wire        sdin_i,
    // Pins
    input  wire        load_strobe_n_i,
    input  wire        clear_n_i,
    input  wire        clear_level_select_i,
    // Outputs
    output wire [15:0] dac_a_o,
    output wire [15:0] dac_b_o,
    output wire [15:0] dac_c_o,
    output wire [15:0] dac_d_o,
    output reg  [3:0]  load_strobe_mask_o,
    output reg         ref_off_o,
    output reg         por_busy_o
);
    // Two-stage synchronisers for every pin
    reg [1:0] sclk_s;
    reg [1:0] sync_s;
    reg [1:0] sdin_s;
    reg [1:0] strb_s;
    reg [1:0] clr_s;
    reg [1:0] sel_s;
    reg       sclk_d;
    reg       sync_d;
    reg       strb_d;
    reg [23:0] shift_r;
    reg [7:0]  por_cnt_r;
    reg        clear_level_r;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_s <= 2'h0;
            sync_s <= 2'h3;
            sdin_s <= 2'h0;
            strb_s <= 2'h3;
            clr_s  <= 2'h3;
            sel_s  <= 2'h0;
            sclk_d <= 1'b0;
            sync_d <= 1'b1;
            strb_d <= 1'b1;
        end else begin
            sclk_s <= {sclk_s[0], sclk_i};
            sync_s <= {sync_s[0], sync_n_i};
            sdin_s <= {sdin_s[0], sdin_i};
            strb_s <= {strb_s[0], load_strobe_n_i};
            clr_s  <= {clr_s[0], clear_n_i};
            sel_s  <= {sel_s[0], clear_level_select_i};
            sclk_d <= sclk_s[1];
            sync_d <= sync_s[1];
            strb_d <= strb_s[1];
        end
    end

    wire sclk_fall = sclk_d & ~sclk_s[1];
    wire frame_end = ~sync_d & sync_s[1];
    wire strb_fall = strb_d & ~strb_s[1];
    wire strb_low  = ~strb_s[1];
    wire clr_low   = ~clr_s[1];
    wire sel_high  = sel_s[1];

    // Shift in data on serial clock falling edges while frame sync is low
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            shift_r <= 24'h000000;
        else if (!sync_s[1] && sclk_fall)
            shift_r <= {shift_r[22:0], sdin_s[1]};
    end

    // Frame fields
    wire [3:0]  cmd  = shift_r[`QDU_CMD_MSB:`QDU_CMD_LSB];
    wire [3:0]  addr = shift_r[`QDU_ADDR_MSB:`QDU_ADDR_LSB];
    wire [15:0] data = shift_r[`QDU_DATA_MSB:`QDU_DATA_LSB];

    // Power-on sequence: hold busy, capturing select level on each busy cycle
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            por_cnt_r     <= 8'h00;
            por_busy_o    <= 1'b1;
            clear_level_r <= 1'b0;
        end else if (por_busy_o) begin
            clear_level_r <= sel_high;
            if ({24'h000000, por_cnt_r} == POR_CYCLES - 1)
                por_busy_o <= 1'b0;
            por_cnt_r <= por_cnt_r + 8'h01;
        end
    end

    wire [15:0] por_code = clear_level_r ? `QDU_CODE_MID : `QDU_CODE_ZERO;
    wire [15:0] clr_code = sel_high ? `QDU_CODE_MID : `QDU_CODE_ZERO;

    // Command decode
    wire take      = frame_end & ~por_busy_o;
    wire sw_rst    = take & (cmd == `QDU_CMD_SW_RST);
    wire hw_clr    = ~por_busy_o & clr_low;
    wire por_clear = por_busy_o | sw_rst;
    wire blocked   = hw_clr;
    wire cmd_wr    = take & ~blocked & (cmd == `QDU_CMD_WR_IN);
    wire cmd_upd   = take & ~blocked & (cmd == `QDU_CMD_UPD_DAC);
    wire cmd_wu    = take & ~blocked & (cmd == `QDU_CMD_WR_UPD);

    // Mask and reference setup registers
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_strobe_mask_o <= `QDU_MASK_RESET;
            ref_off_o          <= `QDU_REF_RESET;
        end else if (take && cmd == `QDU_CMD_MASK) begin
            load_strobe_mask_o <= shift_r[3:0];
        end else if (take && cmd == `QDU_CMD_REF) begin
            ref_off_o <= shift_r[0];
        end
    end

    // Per-channel load requests
    wire [15:0] dac_q [0:3];
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_ch
            // Raw strobe level for writes; a set mask bit blocks strobe edges
            wire wr_in    = (cmd_wr | cmd_wu) & addr[g];
            wire wr_dac   = cmd_wu & addr[g] |
                            cmd_wr & addr[g] & strb_low;
            wire copy     = cmd_upd & addr[g] |
                            strb_fall & ~load_strobe_mask_o[g] &
                            ~blocked & ~por_busy_o;
            qdu_channel u_ch (
                .clock_i      (clock_i),
                .rst_n_i      (rst_n_i),
                .clear_i      (por_clear | hw_clr),
                .clear_code_i (hw_clr ? clr_code : por_code),
                .wr_input_i   (wr_in),
                .wr_dac_i     (wr_dac),
                .copy_i       (copy),
                .data_i       (data),
                .dac_o        (dac_q[g])
            );
        end
    endgenerate

    assign dac_a_o = dac_q[0];
    assign dac_b_o = dac_q[1];
    assign dac_c_o = dac_q[2];
    assign dac_d_o = dac_q[3];
endmodule // qdu_ctrl

// ---- tb/qdu_host_model.sv ----
// Host serial controller model sending 24-bit frames, MSB first.
// Assumes the device shifts data in on the falling serial clock edge.
`timescale 1ns/1ps
module qdu_host_model (
    output logic sclk_o,
    output logic sync_n_o,
    output logic sdin_o
);
    // Serial clock idles high and stands still between frames
    initial begin
        sclk_o = 1;
        sync_n_o = 1;
        sdin_o = 0;
    end
    // One whole frame, ended by the frame sync rise
    task automatic send(input logic [23:0] f);
        sync_n_o = 0;
        for (int k = 23; k >= 0; k--) begin
            sdin_o = f[k];
            #100 sclk_o = 0;
            #100 sclk_o = 1;
        end
        #100 sync_n_o = 1;
        sdin_o = ~f[0]; // Released line shows no stale bit
        #400;
    endtask
endmodule // qdu_host_model

// ---- tb/qdu_ctrl_checker.sv ----
// Port checker for the quad DAC update control block.
// Assumes select pin changes only with the clear pin and frames well apart.
`timescale 1ns/1ps
`include "qdu_regs.vh"
module qdu_ctrl_checker #(parameter POR_CYCLES = 8) (
    input wire        clock_i, rst_n_i, sclk_i, sync_n_i, sdin_i,
    input wire        load_strobe_n_i, clear_n_i, clear_level_select_i,
    input wire [15:0] dac_a_o, dac_b_o, dac_c_o, dac_d_o,
    input wire [3:0]  load_strobe_mask_o,
    input wire        ref_off_o, por_busy_o
);
    // Clear code chosen by the select pin
    wire [15:0] code = clear_level_select_i ? `QDU_CODE_MID : `QDU_CODE_ZERO;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_clear_held; !clear_n_i [*6]; endsequence
    sequence s_frame_busy; (!sync_n_i && load_strobe_n_i) [*6]; endsequence
    a_mask_reset: assert property (por_busy_o |-> load_strobe_mask_o == 4'h0)
        else $error("mask not clear at power-up");
    a_ref_reset: assert property (por_busy_o |-> !ref_off_o)
        else $error("reference not on at power-up");
    a_por_code: assert property ($fell(por_busy_o) |-> dac_d_o == code)
        else $error("wrong power-up code");
    a_por_length: assert property ($fell(por_busy_o) |-> $past(por_busy_o, POR_CYCLES))
        else $error("power-up sequence too short");
    a_clear_code: assert property (s_clear_held |-> dac_a_o == code)
        else $error("output not at clear code");
    a_clear_freeze: assert property (s_clear_held |-> $stable(dac_b_o))
        else $error("output changed during clear");
    a_frame_quiet: assert property (s_frame_busy |-> $stable(dac_c_o))
        else $error("output changed inside a frame");
    a_masked_strobe: assert property ($fell(load_strobe_n_i) && load_strobe_mask_o[0]
        && sync_n_i |-> ##1 $stable(dac_a_o) [*6]) else $error("masked channel updated");
    a_setup_steady: assert property (sync_n_i [*8] |-> $stable(load_strobe_mask_o)
        && $stable(ref_off_o)) else $error("setup changed without frame");
endmodule // qdu_ctrl_checker

// ---- tb/testbench.sv ----
// Self-checking bench for qdu_ctrl driven through the host model.
// Assumes select pin high outside t_clear, so power-up code is midscale.
`timescale 1ns/1ps
`include "qdu_regs.vh"
module testbench;
    localparam POR = 8;
    logic clock_i = 0, rst_n_i = 0, load_strobe_n_i = 1, clear_n_i = 1, sel = 1;
    wire sclk, sync_n, sdin, busy, ref_off;
    wire [15:0] dac_a, dac_b, dac_c, dac_d;
    wire [3:0] mask;
    integer num_errors = 0, checks = 0;
    always #12.5 clock_i = ~clock_i;
    qdu_host_model u_host (.sclk_o(sclk), .sync_n_o(sync_n), .sdin_o(sdin));
    qdu_ctrl #(.POR_CYCLES(POR)) u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .sclk_i(sclk), .sync_n_i(sync_n), .sdin_i(sdin), .load_strobe_n_i(load_strobe_n_i),
        .clear_n_i(clear_n_i), .clear_level_select_i(sel), .dac_a_o(dac_a),
        .dac_b_o(dac_b), .dac_c_o(dac_c), .dac_d_o(dac_d), .load_strobe_mask_o(mask),
        .ref_off_o(ref_off), .por_busy_o(busy));
    task complete_run;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string name, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask
    task send(input logic [23:0] f);
        u_host.send(f);
        repeat (8) @(posedge clock_i);
    endtask
    task strobe;
        @(posedge clock_i) load_strobe_n_i <= 0;
        repeat (4) @(posedge clock_i);
        load_strobe_n_i <= 1;
        repeat (8) @(posedge clock_i);
    endtask
    task t_power_up;
        for (int n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clock_i);
        if (busy !== 1'b0) begin num_errors++; complete_run; end
        chk("mask", 16'h0000, {12'h000, mask});
        chk("ref", 16'h0000, {15'h0000, ref_off});
        chk("dac_a", `QDU_CODE_MID, dac_a);
    endtask
    task t_deferred;
        send(24'h111234);
        chk("dac_a", `QDU_CODE_MID, dac_a);
        strobe;
        chk("dac_a", 16'h1234, dac_a);
    endtask
    task t_direct;
        send(24'h365555);
        chk("dac_b", 16'h5555, dac_b);
        chk("dac_c", 16'h5555, dac_c);
    endtask
    task t_mask;
        send(24'h5F0001);
        chk("mask", 16'h0001, {12'h000, mask});
        send(24'h112222);
        send(24'h183333);
        strobe;
        chk("dac_a", 16'h1234, dac_a);
        chk("dac_d", 16'h3333, dac_d);
        send(24'h210000);
        chk("dac_a", 16'h2222, dac_a);
    endtask
    task t_strobe_low;
        @(posedge clock_i) load_strobe_n_i <= 0;
        repeat (8) @(posedge clock_i);
        send(24'h114444);
        chk("dac_a", 16'h4444, dac_a);
        @(posedge clock_i) load_strobe_n_i <= 1;
    endtask
    task t_ref;
        send(24'h7FFFF1);
        chk("ref", 16'h0001, {15'h0000, ref_off});
        send(24'h7FFFFE);
        chk("ref", 16'h0000, {15'h0000, ref_off});
    endtask
    task t_clear;
        @(posedge clock_i) begin
            clear_n_i <= 0;
            sel <= 0;
        end
        repeat (8) @(posedge clock_i);
        chk("dac_a", `QDU_CODE_ZERO, dac_a);
        send(24'h317777);
        chk("dac_a", `QDU_CODE_ZERO, dac_a);
        clear_n_i <= 1;
        repeat (8) @(posedge clock_i);
        chk("dac_a", `QDU_CODE_ZERO, dac_a);
        sel <= 1;
        repeat (8) @(posedge clock_i);
    endtask
    task t_soft_reset;
        send(24'h311111);
        chk("dac_a", 16'h1111, dac_a);
        send(24'h600000);
        chk("dac_a", `QDU_CODE_MID, dac_a);
        chk("dac_d", `QDU_CODE_MID, dac_d);
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1;
        t_power_up;
        t_deferred;
        t_direct;
        t_mask;
        t_strobe_low;
        t_ref;
        t_clear;
        t_soft_reset;
        complete_run;
    end
endmodule // testbench
bind qdu_ctrl qdu_ctrl_checker #(.POR_CYCLES(POR_CYCLES)) u_chk (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .sclk_i(sclk_i), .sync_n_i(sync_n_i), .sdin_i(sdin_i),
    .load_strobe_n_i(load_strobe_n_i), .clear_n_i(clear_n_i),
    .clear_level_select_i(clear_level_select_i), .dac_a_o(dac_a_o), .dac_b_o(dac_b_o),
    .dac_c_o(dac_c_o), .dac_d_o(dac_d_o), .load_strobe_mask_o(load_strobe_mask_o),
    .ref_off_o(ref_off_o), .por_busy_o(por_busy_o));
